// >>> sfcr_defines.vh
`ifndef SFCR_DEFINES_VH
`define SFCR_DEFINES_VH
// Command words
`define SFCR_CMD_NULL     16'h0000
`define SFCR_CMD_RESET    16'h0011
`define SFCR_CMD_STANDBY  16'h0022
`define SFCR_CMD_WAKEUP   16'h0033
`define SFCR_CMD_LOCK     16'h0555
`define SFCR_CMD_UNLOCK   16'h0655
// Opcode field, bits 15:13
`define SFCR_OP_READ      3'h1
`define SFCR_OP_WRITE     3'h2
`define SFCR_OP_WRITES    3'h3
// Register space
`define SFCR_NUM_REGS     21
`define SFCR_ADDR_ID      5'h00
`define SFCR_ADDR_STAT    5'h02
`define SFCR_READY_HI     8'hFF
// Multi-read header opcode bits
`define SFCR_HDR_OP       3'h1
// Reset cycle length in link frames, minus one
`define SFCR_RESET_FRAMES 4'h2
`endif

// >>> sfcr_host_model.sv
`timescale 1ns/1ns
module sfcr_host_model #(
   parameter WB = 24
) (
   // Serial link
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_din,
   input  wire  i_dout
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_din  = 1'b0;
   end
   // Command in top 16 bits, MSB first
   task automatic frame(input logic [15:0] cmd, output logic [WB-1:0] rsp);
      integer i;
      o_cs_n = 1'b0;
      #800;
      for (i = WB - 1; i >= 0; i--) begin
         o_din = (i >= WB - 16) ? cmd[i-WB+16] : 1'b0;
         #400;
         o_sclk = 1'b1;
         rsp[i] = i_dout;
         #400;
         o_sclk = 1'b0;
      end
      // Released line shows no stale bit
      o_din  = ~o_din;
      o_cs_n = 1'b1;
      #1600;
   endtask
endmodule // sfcr_host_model

// >>> sfcr_regfile.v
`timescale 1ns/1ns
`include "sfcr_defines.vh"
// Register storage with defaults; registers 0 to 9 (channel count at 0) and 16 read only
module sfcr_regfile #(
   parameter NREGS  = `SFCR_NUM_REGS,
   parameter [7:0] CH_CODE = 8'h04
) (
   // Clock and reset
   input  wire       i_core_clk,
   input  wire       i_resetn,
   input  wire       i_soft_rst,
   // Write port
   input  wire       i_we,
   input  wire [4:0] i_waddr,
   input  wire [7:0] i_wdata,
   // Read ports
   input  wire [4:0] i_raddr_a,
   input  wire [4:0] i_raddr_b,
   output reg  [7:0] o_rdata_a,
   output reg  [7:0] o_rdata_b
);
   reg [7:0] mem_r [0:NREGS-1];
   genvar g;
   generate
      for (g = 0; g < NREGS; g = g + 1) begin : g_reg
         wire [7:0] dflt = (g == 0)  ? CH_CODE :
                           (g == 11) ? 8'h60 :
                           (g == 12) ? 8'h3C :
                           (g == 13) ? 8'h08 :
                           (g == 14) ? 8'h86 : 8'h00;
         wire ro = (g < 10) || (g == 16);
         always @(posedge i_core_clk) begin
            if (!i_resetn || i_soft_rst)
               mem_r[g] <= dflt;
            else if (i_we && !ro && (i_waddr == g))
               mem_r[g] <= i_wdata;
         end
      end
   endgenerate
   always @* begin
      // Absent addresses read as zero
      o_rdata_a = (i_raddr_a < NREGS) ? mem_r[i_raddr_a] : 8'h00;
      o_rdata_b = (i_raddr_b < NREGS) ? mem_r[i_raddr_b] : 8'h00;
   end
endmodule // sfcr_regfile

// >>> sfcr_responder.v
`timescale 1ns/1ns
`include "sfcr_defines.vh"
module sfcr_responder #(
   parameter       WORD_BITS = 24,
   parameter [7:0] CH_CODE   = 8'h04
) (
   // Clock and reset
   input  wire i_core_clk,
   input  wire i_resetn,
   // Serial link from host
   input  wire i_sclk,
   input  wire i_cs_n,
   input  wire i_din,
   // Serial link to host
   output reg  o_dout,
   output reg  o_dout_oe,
   // Device state
   output reg  o_standby,
   output reg  o_locked,
   output reg  o_ready
);
   localparam ST_RESET = 2'h0;
   localparam ST_READY = 2'h1;
   localparam ST_RUN   = 2'h2;

   localparam RS_READY = 3'h0;
   localparam RS_ECHO  = 3'h1;
   localparam RS_REG   = 3'h2;
   localparam RS_HDR   = 3'h3;
   localparam RS_DATA  = 3'h4;

   // Input synchronisers
   reg [2:0] sclk_s1_r;
   reg [2:0] sclk_s2_r;
   reg       sclk_d_r;
   always @(posedge i_core_clk) begin
      if (!i_resetn) begin
         sclk_s1_r <= 3'h7;
         sclk_s2_r <= 3'h7;
         sclk_d_r  <= 1'b0;
      end else begin
         sclk_s1_r <= {i_cs_n, i_din, i_sclk};
         sclk_s2_r <= sclk_s1_r;
         sclk_d_r  <= sclk_s2_r[0];
      end
   end
   wire sclk_q = sclk_s2_r[0];
   wire din_q  = sclk_s2_r[1];
   wire csn_q  = sclk_s2_r[2];
   reg  csn_d_r;
   wire rise   = sclk_q & ~sclk_d_r & ~csn_q;
   wire fall   = ~sclk_q & sclk_d_r & ~csn_q;
   wire f_beg  = ~csn_q & csn_d_r;
   wire f_end  = csn_q & ~csn_d_r;

   // State
   reg [1:0]  st_r;
   reg [3:0]  rst_cnt_r;
   reg [15:0] cmd_sh_r;
   reg [5:0]  bit_cnt_r;
   reg [2:0]  rsp_r;
   reg [15:0] rsp_word_r;
   reg [WORD_BITS-1:0] tx_sh_r;
   reg [4:0]  rd_addr_r;
   reg [8:0]  rd_left_r;
   reg        soft_rst_r;
   reg        rst_pend_r;
   reg        we_r;
   reg [4:0]  waddr_r;
   reg [7:0]  wdata_r;

   wire [7:0] rdata_a;
   wire [7:0] rdata_b;
   reg  [4:0] raddr_a;
   reg  [4:0] raddr_b;

   sfcr_regfile #(
      .NREGS   (`SFCR_NUM_REGS),
      .CH_CODE (CH_CODE)
   ) u_regs (
      .i_core_clk (i_core_clk),
      .i_resetn   (i_resetn),
      .i_soft_rst (soft_rst_r),
      .i_we       (we_r),
      .i_waddr    (waddr_r),
      .i_wdata    (wdata_r),
      .i_raddr_a  (raddr_a),
      .i_raddr_b  (raddr_b),
      .o_rdata_a  (rdata_a),
      .o_rdata_b  (rdata_b)
   );

   // Command captured in the frame just ended
   wire [15:0] cmd  = cmd_sh_r;
   wire [2:0]  op   = cmd[15:13];
   wire [4:0]  addr = cmd[12:8];
   wire        rd_busy = (rsp_r == RS_HDR) || (rsp_r == RS_DATA);
   wire        lock_ok = (cmd == `SFCR_CMD_UNLOCK) || (cmd == `SFCR_CMD_NULL) ||
                         (op == `SFCR_OP_READ);

   // Read address selection for response building
   always @* begin
      raddr_a = `SFCR_ADDR_STAT;
      raddr_b = 5'h00;
      if (rd_busy) begin
         raddr_a = rd_addr_r;
         raddr_b = rd_addr_r + 5'h01;
      end else if (op == `SFCR_OP_READ) begin
         raddr_a = addr;
      end else if (op == `SFCR_OP_WRITE) begin
         raddr_a = addr;
      end
   end

   // Second byte of a pair past the count or the map is zero
   wire [7:0] data_b = ((rd_left_r > 9'h001) &&
                        ({1'b0, rd_addr_r} + 6'h01 < `SFCR_NUM_REGS)) ?
                       rdata_b : 8'h00;

   always @(posedge i_core_clk) begin
      if (!i_resetn) begin
         csn_d_r    <= 1'b1;
         st_r       <= ST_RESET;
         rst_cnt_r  <= 4'h0;
         cmd_sh_r   <= 16'h0000;
         bit_cnt_r  <= 6'h00;
         rsp_r      <= RS_READY;
         rsp_word_r <= {`SFCR_READY_HI, CH_CODE};
         tx_sh_r    <= {WORD_BITS{1'b0}};
         rd_addr_r  <= 5'h00;
         rd_left_r  <= 9'h000;
         soft_rst_r <= 1'b0;
         rst_pend_r <= 1'b0;
         we_r       <= 1'b0;
         waddr_r    <= 5'h00;
         wdata_r    <= 8'h00;
         o_dout     <= 1'b0;
         o_dout_oe  <= 1'b0;
         o_standby  <= 1'b0;
         o_locked   <= 1'b1;
         o_ready    <= 1'b0;
      end else begin
         csn_d_r    <= csn_q;
         soft_rst_r <= 1'b0;
         we_r       <= 1'b0;
         o_dout_oe  <= ~csn_q;
         if (soft_rst_r) begin
            o_standby <= 1'b0;
         end
         if (f_beg) begin
            // Response in MSBs, zero-filled below
            tx_sh_r   <= {rsp_word_r, {(WORD_BITS-16){1'b0}}};
            o_dout    <= rsp_word_r[15];
            bit_cnt_r <= 6'h00;
         end else if (fall) begin
            tx_sh_r <= {tx_sh_r[WORD_BITS-2:0], 1'b0};
            o_dout  <= tx_sh_r[WORD_BITS-2];
         end
         if (rise && bit_cnt_r < 6'h10) begin
            cmd_sh_r  <= {cmd_sh_r[14:0], din_q};
            bit_cnt_r <= bit_cnt_r + 6'h01;
         end
         if (f_end) begin
            // Execution at frame end; answer goes out next frame
            case (st_r)
               ST_RESET: begin
                  // Refuse all until reset cycle done
                  rsp_r      <= RS_READY;
                  rsp_word_r <= {`SFCR_READY_HI, CH_CODE};
                  if (rst_cnt_r == `SFCR_RESET_FRAMES) begin
                     st_r    <= ST_READY;
                     o_ready <= 1'b1;
                  end else begin
                     rst_cnt_r <= rst_cnt_r + 4'h1;
                  end
               end
               ST_READY: begin
                  rsp_r      <= RS_READY;
                  rsp_word_r <= {`SFCR_READY_HI, CH_CODE};
                  if (cmd == `SFCR_CMD_UNLOCK) begin
                     st_r       <= ST_RUN;
                     o_locked   <= 1'b0;
                     rsp_r      <= RS_ECHO;
                     rsp_word_r <= cmd;
                  end
               end
               ST_RUN: begin
                  if (rd_busy) begin
                     // Ignore commands while draining
                     rsp_r      <= (rd_left_r > 9'h002) ? RS_DATA : RS_ECHO;
                     rsp_word_r <= {rdata_a, data_b};
                     if (rd_left_r > 9'h002) begin
                        rd_addr_r <= rd_addr_r + 5'h02;
                        rd_left_r <= rd_left_r - 9'h002;
                     end else begin
                        rd_left_r <= 9'h000;
                        rsp_r     <= RS_REG;
                     end
                  end else if (o_locked && !lock_ok) begin
                     rsp_r      <= RS_REG;
                     rsp_word_r <= {`SFCR_OP_READ, `SFCR_ADDR_STAT, rdata_a};
                  end else if (cmd == `SFCR_CMD_NULL) begin
                     rsp_r      <= RS_REG;
                     rsp_word_r <= {`SFCR_OP_READ, `SFCR_ADDR_STAT, rdata_a};
                  end else if (cmd == `SFCR_CMD_RESET) begin
                     // Reset starts after this frame
                     soft_rst_r <= 1'b1;
                     st_r       <= ST_READY;
                     o_locked   <= 1'b1;
                     o_ready    <= 1'b1;
                     rsp_r      <= RS_READY;
                     rsp_word_r <= {`SFCR_READY_HI, CH_CODE};
                  end else if (cmd == `SFCR_CMD_STANDBY) begin
                     o_standby  <= 1'b1;
                     rsp_r      <= RS_ECHO;
                     rsp_word_r <= cmd;
                  end else if (cmd == `SFCR_CMD_WAKEUP) begin
                     o_standby  <= 1'b0;
                     rsp_r      <= RS_ECHO;
                     rsp_word_r <= cmd;
                  end else if (cmd == `SFCR_CMD_LOCK) begin
                     o_locked   <= 1'b1;
                     rsp_r      <= RS_ECHO;
                     rsp_word_r <= cmd;
                  end else if (cmd == `SFCR_CMD_UNLOCK) begin
                     o_locked   <= 1'b0;
                     rsp_r      <= RS_ECHO;
                     rsp_word_r <= cmd;
                  end else if (op == `SFCR_OP_READ && cmd[7:0] == 8'h00) begin
                     rsp_r      <= RS_REG;
                     rsp_word_r <= {`SFCR_OP_READ, addr, rdata_a};
                  end else if (op == `SFCR_OP_READ) begin
                     // Header: start address and count minus one
                     rsp_r      <= RS_HDR;
                     rsp_word_r <= {`SFCR_HDR_OP, addr, cmd[7:0]};
                     rd_addr_r  <= addr;
                     rd_left_r  <= {1'b0, cmd[7:0]} + 9'h001;
                  end else if (op == `SFCR_OP_WRITE) begin
                     we_r       <= 1'b1;
                     waddr_r    <= addr;
                     wdata_r    <= cmd[7:0];
                     rsp_r      <= RS_REG;
                     // Shows new content for writable addresses
                     rsp_word_r <= {`SFCR_OP_READ, addr,
                                    (addr < `SFCR_NUM_REGS && addr > 5'h09 &&
                                     addr != 5'h10) ? cmd[7:0] : rdata_a};
                  end else begin
                     // Unknown command: status readback
                     rsp_r      <= RS_REG;
                     rsp_word_r <= {`SFCR_OP_READ, `SFCR_ADDR_STAT, rdata_a};
                  end
               end
               default: begin
                  st_r <= ST_RESET;
               end
            endcase
         end
      end
   end
endmodule // sfcr_responder

// >>> sfcr_responder_props.sv
`timescale 1ns/1ns
module sfcr_responder_props (
   // Clock and reset
   input wire i_core_clk,
   input wire i_resetn,
   // Link and state
   input wire i_cs_n,
   input wire o_dout_oe,
   input wire o_standby,
   input wire o_locked,
   input wire o_ready
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence s_idle;
      i_cs_n [*4];
   endsequence
   sequence s_busy;
      !i_cs_n [*4];
   endsequence
   // Frame closed at this edge and two edges before
   sequence s_end;
      i_cs_n && $past(i_cs_n, 2);
   endsequence
   a_reset_locked_idle: assert property ($rose(i_resetn) |-> o_locked && !o_ready && !o_standby)
      else $error("state wrong after reset");
   a_idle_no_drive: assert property (s_idle |-> !o_dout_oe)
      else $error("output driven outside frame");
   a_frame_drives_out: assert property (s_busy |-> o_dout_oe)
      else $error("output not driven in frame");
   a_ready_at_end: assert property ($rose(o_ready) |-> s_end)
      else $error("ready rose inside frame");
   a_standby_when_open: assert property ($rose(o_standby) |-> s_end ##0 ($past(o_ready) && !$past(o_locked)))
      else $error("standby entered wrongly");
   a_wake_when_open: assert property ($fell(o_standby) |-> s_end ##0 !$past(o_locked))
      else $error("standby left wrongly");
   a_lock_at_end: assert property ($changed(o_locked) |-> s_end ##0 o_ready)
      else $error("lock changed inside frame");
   a_ready_held: assert property (!$fell(o_ready))
      else $error("ready dropped");
endmodule // sfcr_responder_props
bind sfcr_responder sfcr_responder_props u_props (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
   .i_cs_n(i_cs_n), .o_dout_oe(o_dout_oe), .o_standby(o_standby), .o_locked(o_locked),
   .o_ready(o_ready));

// >>> sfcr_responder_tb.sv
`timescale 1ns/1ns
module sfcr_responder_tb;
   localparam        WB  = 24;
   localparam [7:0]  CH  = 8'h04;
   localparam [15:0] RDY = {8'hFF, CH};
   localparam [15:0] STA = 16'h2200;
   logic          clk;
   logic          rst_n;
   wire           sclk;
   wire           cs_n;
   wire           din;
   wire           dout;
   wire           stby;
   wire           lckd;
   wire           rdy;
   logic [WB-1:0] rsp;
   integer        err_count;
   integer        comparisons;
   sfcr_responder #(.WORD_BITS(WB), .CH_CODE(CH)) dut (.i_core_clk(clk), .i_resetn(rst_n),
      .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_dout_oe(),
      .o_standby(stby), .o_locked(lckd), .o_ready(rdy));
   sfcr_host_model #(.WB(WB)) host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [WB-1:0] got, input logic [WB-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [15:0] cmd);
      @(negedge clk);
      host.frame(cmd, rsp);
   endtask
   // This frame answers the previous command
   task automatic step(input logic [15:0] cmd, input logic [15:0] exp);
      send(cmd);
      check(rsp, {exp, 8'h00});
   endtask
   task automatic flag(input logic got, input logic exp);
      check({23'h0, got}, {23'h0, exp});
   endtask
   task automatic t_power_up;
      integer n;
      n = 0;
      while (rdy !== 1'b1 && n < 8) begin
         send(16'h0000);
         n++;
      end
      step(16'h0033, RDY);
      flag(lckd, 1'b1);
      step(16'h0655, RDY);
      step(16'h0000, 16'h0655);
      flag(lckd, 1'b0);
   endtask
   task automatic t_access;
      step(16'h2000, STA);
      step(16'h515A, 16'h2004);
      step(16'h52C3, 16'h315A);
      step(16'h54A5, 16'h32C3);
      step(16'h3104, 16'h34A5);
   endtask
   task automatic t_multi;
      step(16'h0555, 16'h3104);
      step(16'h0555, 16'h5AC3);
      step(16'h0555, 16'h00A5);
      step(16'h0000, 16'h0000);
      flag(lckd, 1'b0);
      send(16'h0000);
   endtask
   task automatic t_lock;
      step(16'h0555, STA);
      step(16'h0022, 16'h0555);
      step(16'h2000, STA);
      flag(stby, 1'b0);
      flag(lckd, 1'b1);
      step(16'h0655, 16'h2004);
      step(16'h0000, 16'h0655);
   endtask
   task automatic t_standby;
      step(16'h0022, STA);
      step(16'h5277, 16'h0022);
      flag(stby, 1'b1);
      step(16'h0033, 16'h3277);
      step(16'h0000, 16'h0033);
      flag(stby, 1'b0);
   endtask
   task automatic t_soft_reset;
      step(16'h0011, STA);
      step(16'h0000, RDY);
      flag(lckd, 1'b1);
      step(16'h0655, RDY);
      step(16'h3100, 16'h0655);
      step(16'h0000, 16'h3100);
   endtask
   task automatic tally_and_finish;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      err_count = 0;
      comparisons = 0;
      rst_n = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_power_up;
      t_access;
      t_multi;
      t_lock;
      t_standby;
      t_soft_reset;
      tally_and_finish;
   end
   initial begin
      #3000000;
      err_count++;
      tally_and_finish;
   end
endmodule // sfcr_responder_tb
